//--- rtl/csm_regs.sv
// Purpose: Special state registers: flags, exception number, execution
//          state, exception masks and thread configuration
// Assumes: Core decodes moves and change-state instructions into strobes
// Notes:   Move reads answer one cycle after the strobe
`timescale 1ns/1ns
// Overview of operation
// (RULE1) Negative and zero flags track each operation result.
// (RULE2) Carry flag is one on add carry or subtract without borrow.
// (RULE3) Overflow flag follows whether the operation overflowed.
// (RULE4) Saturation flag is sticky until software writes it to zero.
// (RULE5) Low nine bits report the current exception number.
// (RULE6) External interrupt lines report as line index plus sixteen.
// (RULE7) Execution state lives in bits 26:25 and 15:10, rest reserved.
// (RULE8) Move reads of execution state give zero, writes are ignored.
// (RULE9) Interrupted multi-transfer records next register in bits 15:12.
// (RULE10) After service the transfer resumes at the recorded register.
// (RULE11) Bits 26:25 and 11:10 are zero while multi-transfer state held.
// (RULE12) Predication instruction conditions up to four following ones.
// (RULE13) Masks move-readable and writable; change-state sets two masks.
// (RULE14) Configurable-priority mask blocks all configurable exceptions.
// (RULE15) All-but-NMI mask blocks every exception except NMI.
// (RULE16) Leaving any non-NMI handler clears the all-but-NMI mask.
// (RULE17) Nonzero threshold blocks exceptions with priority value >= it.
// (RULE18) Only threshold bits 7:5 exist; 4:0 read zero.
// (RULE19) Thread configuration bit 1 selects main or process stack.
// (RULE20) In handler mode stack-select reads zero and ignores writes.
// (RULE21) Bit 0 sets thread privilege; exception entry/return update it. The code changes bit 0 only on a write; entry/return update only bit 1.
// (RULE22) Software issues a sync barrier after changing stack pointer.
// (RULE23) Only privileged software may write thread configuration.
// (RULE24) Writes to exception number bits are discarded.
// (RULE25) Reserved bits read zero and discard writes.
module csm_regs (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        flag_upd,
    input  wire logic        flag_n,
    input  wire logic        flag_z,
    input  wire logic        flag_c,
    input  wire logic        flag_v,
    input  wire logic        sat_hit,
    input  wire logic        msr_valid,
    input  wire logic [4:0]  msr_sel,
    input  wire logic [31:0] msr_wdata,
    input  wire logic        mrs_valid,
    input  wire logic [4:0]  mrs_sel,
    input  wire logic        cps_valid,
    input  wire logic        cps_set,
    input  wire logic        cps_pri,
    input  wire logic        cps_flt,
    input  wire logic        exc_entry,
    input  wire logic [8:0]  exc_entry_num,
    input  wire logic        exc_return,
    input  wire logic [8:0]  exc_return_num,
    input  wire logic        exc_return_spsel,
    input  wire logic        xfer_suspend,
    input  wire logic [3:0]  xfer_next_reg,
    input  wire logic        pred_load,
    input  wire logic [7:0]  pred_value,
    input  wire logic        pred_advance,
    input  wire logic        gate_req,
    input  wire logic [8:0]  gate_num,
    input  wire logic [7:0]  gate_pri,
    output logic [31:0] mrs_rdata_q,
    output logic        mrs_done_q,
    output logic [4:0]  flags_q,
    output logic [8:0]  exc_num_q,
    output logic        pri_block_q,
    output logic        flt_block_q,
    output logic [2:0]  thresh_q,
    output logic        spsel_q,
    output logic        unpriv_q,
    output logic        xfer_held_q,
    output logic [3:0]  xfer_reg_q,
    output logic        xfer_resume_q,
    output logic [3:0]  xfer_resume_reg_q,
    output logic [7:0]  pred_state_q,
    output logic [31:0] psr_stack_q,
    output logic        gate_done_q,
    output logic        gate_allow_q
);
    ////////////////////////////////////////////////////////////////////
    // Decode helpers
    logic handler_mode;
    logic privileged;
    logic wr_priv;
    logic wr_flags;
    logic wr_pri;
    logic wr_flt;
    logic wr_thresh;
    logic wr_ctrl;
    logic [7:0] thresh_full;
    logic gate_allow;
    function automatic logic sel_has_flags(input logic [4:0] sel);
        return (sel == csm_pkg::SEL_FLAGS) || (sel == csm_pkg::SEL_IFLAGS)
            || (sel == csm_pkg::SEL_EFLAGS) || (sel == csm_pkg::SEL_PSR);
    endfunction : sel_has_flags
    function automatic logic sel_has_excnum(input logic [4:0] sel);
        return (sel == csm_pkg::SEL_IFLAGS) || (sel == csm_pkg::SEL_PSR)
            || (sel == csm_pkg::SEL_EXCNUM) || (sel == csm_pkg::SEL_IEXEC);
    endfunction : sel_has_excnum
    // Stacked view of execution state; multi-transfer form zeroes the
    // condition bits
    function automatic logic [31:0] exec_view(input logic held,
                                              input logic [3:0] reg_idx,
                                              input logic [7:0] pred);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[csm_pkg::ES_TBIT] = 1'b1;
        if (held) begin
            v[csm_pkg::ICI_REG_LSB +: 4] = reg_idx;        // [RULE11]
        end else begin
            v[csm_pkg::ES_HI_LSB +: 2] = pred[1:0];        // [RULE7]
            v[csm_pkg::ES_LO_LSB +: 6] = pred[7:2];
        end
        return v;
    endfunction : exec_view
    assign handler_mode = (exc_num_q != csm_pkg::EXC_THREAD);
    assign privileged   = handler_mode || !unpriv_q;
    assign wr_flags     = msr_valid && sel_has_flags(msr_sel);
    assign wr_priv      = msr_valid && privileged;
    assign wr_pri       = wr_priv && (msr_sel == csm_pkg::SEL_PRIBLK);
    assign wr_flt       = wr_priv && (msr_sel == csm_pkg::SEL_FLTBLK);
    assign wr_thresh    = wr_priv && (msr_sel == csm_pkg::SEL_THRESH);
    assign wr_ctrl      = wr_priv && (msr_sel == csm_pkg::SEL_CTRL); // [RULE23]
    assign thresh_full  = {thresh_q, 5'b00000};            // [RULE18]
    ////////////////////////////////////////////////////////////////////
    // Condition flags
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags_q <= 5'b00000;
        end else begin
            if (flag_upd) begin
                flags_q[4] <= flag_n;                      // [RULE1]
                flags_q[3] <= flag_z;                      // [RULE1]
                flags_q[2] <= flag_c;                      // [RULE2]
                flags_q[1] <= flag_v;                      // [RULE3]
            end else if (wr_flags) begin
                flags_q[4:1] <= msr_wdata[csm_pkg::FLAG_N_BIT -: 4];
            end
            // Saturation is sticky; a hit beats a software clear
            if (sat_hit) begin
                flags_q[0] <= 1'b1;                        // [RULE4]
            end else if (wr_flags) begin
                flags_q[0] <= msr_wdata[csm_pkg::FLAG_Q_BIT]; // [RULE4]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Exception number: only entry and return move it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            exc_num_q <= csm_pkg::EXC_THREAD;
        end else if (exc_entry) begin
            exc_num_q <= exc_entry_num;                    // [RULE5] [RULE6]
        end else if (exc_return) begin
            exc_num_q <= exc_return_num;                   // [RULE24]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Exception masks
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pri_block_q <= 1'b0;
        end else if (cps_valid && privileged && cps_pri) begin
            pri_block_q <= cps_set;                        // [RULE13]
        end else if (wr_pri) begin
            pri_block_q <= msr_wdata[0];                   // [RULE13]
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flt_block_q <= 1'b0;
        end else if (exc_return && (exc_num_q != csm_pkg::EXC_NMI)) begin
            flt_block_q <= 1'b0;                           // [RULE16]
        end else if (cps_valid && privileged && cps_flt) begin
            flt_block_q <= cps_set;                        // [RULE13]
        end else if (wr_flt) begin
            flt_block_q <= msr_wdata[0];                   // [RULE13]
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            thresh_q <= csm_pkg::THRESH_RST[7:5];
        end else if (wr_thresh) begin
            thresh_q <= msr_wdata[7:5];                    // [RULE18]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Thread configuration
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            spsel_q <= 1'b0;
        end else if (exc_entry) begin
            spsel_q <= 1'b0;                               // [RULE20]
        end else if (exc_return) begin
            spsel_q <= (exc_return_num == csm_pkg::EXC_THREAD) &&
                       exc_return_spsel;                   // [RULE21]
        end else if (wr_ctrl && !handler_mode) begin
            spsel_q <= msr_wdata[csm_pkg::CTRL_SPSEL_BIT]; // [RULE19] [RULE20]
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            unpriv_q <= 1'b0;
        end else if (wr_ctrl) begin
            unpriv_q <= msr_wdata[csm_pkg::CTRL_UNPRIV_BIT]; // [RULE21]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Multi-transfer suspend and resume
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xfer_held_q <= 1'b0;
            xfer_reg_q  <= 4'h0;
        end else if (xfer_suspend) begin
            xfer_held_q <= 1'b1;                           // [RULE9]
            xfer_reg_q  <= xfer_next_reg;                  // [RULE9]
        end else if (exc_return && xfer_held_q) begin
            xfer_held_q <= 1'b0;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xfer_resume_q     <= 1'b0;
            xfer_resume_reg_q <= 4'h0;
        end else begin
            xfer_resume_q <= exc_return && xfer_held_q;    // [RULE10]
            if (exc_return && xfer_held_q) begin
                xfer_resume_reg_q <= xfer_reg_q;           // [RULE10]
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Predicated group: top three bits are base condition, low five bits the mask
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pred_state_q <= 8'h00;
        end else if (pred_load) begin
            pred_state_q <= pred_value;                    // [RULE12]
        end else if (xfer_suspend) begin
            pred_state_q <= 8'h00;
        end else if (pred_advance) begin
            if (pred_state_q[2:0] == 3'b000) begin
                pred_state_q <= 8'h00;                     // [RULE12]
            end else begin
                pred_state_q[4:0] <= {pred_state_q[3:0], 1'b0}; // [RULE12]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stacked status word, as exception entry would push it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            psr_stack_q <= csm_pkg::PSR_RESET;
        end else begin
            psr_stack_q <= {flags_q, 27'h0000000}
                         | {23'h000000, exc_num_q}
                         | exec_view(xfer_held_q, xfer_reg_q, pred_state_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Move-from reads
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mrs_rdata_q <= 32'h0000_0000;
            mrs_done_q  <= 1'b0;
        end else begin
            mrs_done_q  <= mrs_valid;
            mrs_rdata_q <= 32'h0000_0000;                  // [RULE8] [RULE25]
            if (mrs_valid) begin
                if (sel_has_flags(mrs_sel)) begin
                    mrs_rdata_q[31:27] <= flags_q;
                end
                if (sel_has_excnum(mrs_sel) && privileged) begin
                    mrs_rdata_q[8:0] <= exc_num_q;         // [RULE5]
                end
                if (privileged) begin
                    unique case (mrs_sel)
                        csm_pkg::SEL_PRIBLK: mrs_rdata_q[0] <= pri_block_q;
                        csm_pkg::SEL_FLTBLK: mrs_rdata_q[0] <= flt_block_q;
                        csm_pkg::SEL_THRESH: mrs_rdata_q[7:0] <= thresh_full;
                        csm_pkg::SEL_CTRL:
                            mrs_rdata_q[1:0] <= {spsel_q && !handler_mode,
                                                 unpriv_q}; // [RULE20]
                        default: ;
                    endcase
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Activation gate
    csm_exc_gate u_gate (
        .req_num   (gate_num),
        .req_pri   (gate_pri),
        .pri_block (pri_block_q),
        .flt_block (flt_block_q),
        .threshold (thresh_full),
        .allow     (gate_allow)
    );
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gate_done_q  <= 1'b0;
            gate_allow_q <= 1'b0;
        end else begin
            gate_done_q  <= gate_req;
            gate_allow_q <= gate_req && gate_allow;        // [RULE14] [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sat_sticky_a: assert property (flags_q[0] && !wr_flags // [RULE4]
        |=> flags_q[0])
        else $error("saturation flag dropped without a write");
    sat_set_a: assert property (sat_hit |=> flags_q[0]) // [RULE4]
        else $error("saturation hit not recorded");
    flag_load_a: assert property (flag_upd |=> // [RULE1]
        flags_q[4:1] == $past({flag_n, flag_z, flag_c, flag_v}))
        else $error("condition flags not loaded");
    excnum_hold_a: assert property (!exc_entry && !exc_return |=> // [RULE24]
        $stable(exc_num_q))
        else $error("exception number changed without entry or return");
    exec_read_a: assert property (mrs_valid && // [RULE8]
        mrs_sel == csm_pkg::SEL_EXEC |=> mrs_done_q && mrs_rdata_q == 32'h0)
        else $error("execution state read not zero");
    flt_clear_a: assert property (exc_return && // [RULE16]
        exc_num_q != csm_pkg::EXC_NMI |=> !flt_block_q)
        else $error("fault mask not cleared on handler exit");
    thresh_low_a: assert property (mrs_valid && // [RULE18]
        mrs_sel == csm_pkg::SEL_THRESH |=> mrs_rdata_q[4:0] == 5'h00)
        else $error("threshold low bits not zero");
    handler_sp_a: assert property (exc_entry |=> !spsel_q ##1 // [RULE20]
        (!spsel_q || exc_return || $past(exc_return)))
        else $error("stack select set in handler mode");
    unpriv_ctrl_a: assert property (msr_valid && !privileged && // [RULE23]
        msr_sel == csm_pkg::SEL_CTRL |=> $stable(unpriv_q))
        else $error("unprivileged write changed configuration");
    ici_zero_a: assert property (xfer_held_q |=> // [RULE11]
        psr_stack_q[26:25] == 2'b00 && psr_stack_q[11:10] == 2'b00 &&
        psr_stack_q[15:12] == $past(xfer_reg_q))
        else $error("multi-transfer state layout wrong");
    resume_a: assert property (exc_return && xfer_held_q |=> // [RULE10]
        xfer_resume_q && xfer_resume_reg_q == $past(xfer_reg_q))
        else $error("suspended transfer not resumed");
    nmi_pass_a: assert property (gate_req && // [RULE15]
        gate_num == csm_pkg::EXC_NMI |=> gate_allow_q)
        else $error("NMI was blocked");
    pri_blk_a: assert property (gate_req && pri_block_q && // [RULE14]
        gate_num > csm_pkg::EXC_HARD |=> !gate_allow_q)
        else $error("configurable exception passed priority block");
    irq_entry_c: cover property (exc_entry &&
        exc_entry_num >= csm_pkg::EXC_IRQ_BASE ##[1:20] exc_return);
    suspend_c: cover property (xfer_suspend ##[1:20] xfer_resume_q);
    cps_c: cover property (cps_valid && cps_set && cps_flt ##1 flt_block_q);
    thresh_c: cover property (gate_req && thresh_q != 3'b000 ##1
        !gate_allow_q);
endmodule : csm_regs

//--- rtl/csm_pkg.sv
// Purpose: Shared constants for the core status and mask register block
// Assumes: 32-bit special registers, 9-bit exception numbers
// Notes:   Selector codes name the special register a move targets
package csm_pkg;
    // Condition flag register field positions
    localparam int FLAG_N_BIT = 31;
    localparam int FLAG_Z_BIT = 30;
    localparam int FLAG_C_BIT = 29;
    localparam int FLAG_V_BIT = 28;
    localparam int FLAG_Q_BIT = 27;
    // Exception number field
    localparam int EXC_NUM_W  = 9;
    localparam logic [8:0] EXC_THREAD  = 9'h000;
    localparam logic [8:0] EXC_NMI     = 9'h002;
    localparam logic [8:0] EXC_HARD    = 9'h003;
    localparam logic [8:0] EXC_MEMMAN  = 9'h004;
    localparam logic [8:0] EXC_BUS     = 9'h005;
    localparam logic [8:0] EXC_USAGE   = 9'h006;
    localparam logic [8:0] EXC_SVCALL  = 9'h00B;
    localparam logic [8:0] EXC_PENDSRV = 9'h00E;
    localparam logic [8:0] EXC_SYSTEM_TICK_TIMER = 9'h00F;
    localparam logic [8:0] EXC_IRQ_BASE = 9'h010;
    // Execution state field positions
    localparam int ES_HI_LSB   = 25;
    localparam int ES_LO_LSB   = 10;
    localparam int ES_TBIT     = 24;
    localparam int ICI_REG_LSB = 12;
    // Mask and thread configuration registers
    localparam logic [7:0] THRESH_IMPL = 8'hE0;
    localparam int CTRL_SPSEL_BIT = 1;
    localparam int CTRL_UNPRIV_BIT = 0;
    // Reset values
    localparam logic [31:0] PSR_RESET  = 32'h0100_0000;
    localparam logic [7:0]  THRESH_RST = 8'h00;
    // Special register selector codes
    localparam logic [4:0] SEL_FLAGS   = 5'h00;
    localparam logic [4:0] SEL_IFLAGS  = 5'h01;
    localparam logic [4:0] SEL_EFLAGS  = 5'h02;
    localparam logic [4:0] SEL_PSR     = 5'h03;
    localparam logic [4:0] SEL_EXCNUM  = 5'h05;
    localparam logic [4:0] SEL_EXEC    = 5'h06;
    localparam logic [4:0] SEL_IEXEC   = 5'h07;
    localparam logic [4:0] SEL_PRIBLK  = 5'h10;
    localparam logic [4:0] SEL_THRESH  = 5'h11;
    localparam logic [4:0] SEL_FLTBLK  = 5'h13;
    localparam logic [4:0] SEL_CTRL    = 5'h14;
endpackage : csm_pkg

//--- rtl/csm_exc_gate.sv
// Purpose: Decide whether a pending exception may activate under the masks
// Assumes: Priority value is already aligned to the implemented bits
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ns
module csm_exc_gate (
    input  wire logic [8:0] req_num,
    input  wire logic [7:0] req_pri,
    input  wire logic       pri_block,
    input  wire logic       flt_block,
    input  wire logic [7:0] threshold,
    output logic            allow
);
    logic fixed_pri;
    logic is_nmi;
    always_comb begin
        is_nmi    = (req_num == csm_pkg::EXC_NMI);
        // Reset, NMI and hard fault carry fixed priority
        fixed_pri = (req_num <= csm_pkg::EXC_HARD);
        allow     = 1'b1;
        if (flt_block && !is_nmi) begin                    // [RULE15]
            allow = 1'b0;
        end
        if (pri_block && !fixed_pri) begin                 // [RULE14]
            allow = 1'b0;
        end
        if ((threshold != 8'h00) && !fixed_pri &&
            (req_pri >= threshold)) begin                  // [RULE17]
            allow = 1'b0;
        end
    end
endmodule : csm_exc_gate

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the status and mask register block
// Assumes: Strobes driven on falling edges, outputs read one cycle later
// Notes:   Every strobe is a one-cycle pulse
`timescale 1ns/1ns
module tb_top;
    logic        mclk, reset, flag_upd, flag_n, flag_z, flag_c, flag_v;
    logic        sat_hit, msr_valid, mrs_valid, cps_valid, cps_set, cps_pri;
    logic        cps_flt, exc_entry, exc_return, exc_return_spsel;
    logic        xfer_suspend, pred_load, pred_advance, gate_req;
    logic [4:0]  msr_sel, mrs_sel, flags_q;
    logic [31:0] msr_wdata, mrs_rdata_q, psr_stack_q;
    logic [8:0]  exc_entry_num, exc_return_num, gate_num, exc_num_q;
    logic [3:0]  xfer_next_reg, xfer_reg_q, xfer_resume_reg_q;
    logic [7:0]  pred_value, gate_pri, pred_state_q;
    logic [2:0]  thresh_q;
    logic        mrs_done_q, pri_block_q, flt_block_q, spsel_q, unpriv_q;
    logic        xfer_held_q, xfer_resume_q, gate_done_q, gate_allow_q;
    int          n_fail, total_checks, cycles;
    csm_regs dut (.mclk(mclk), .reset(reset), .flag_upd(flag_upd),
        .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c), .flag_v(flag_v),
        .sat_hit(sat_hit), .msr_valid(msr_valid), .msr_sel(msr_sel),
        .msr_wdata(msr_wdata), .mrs_valid(mrs_valid), .mrs_sel(mrs_sel),
        .cps_valid(cps_valid), .cps_set(cps_set), .cps_pri(cps_pri),
        .cps_flt(cps_flt), .exc_entry(exc_entry),
        .exc_entry_num(exc_entry_num), .exc_return(exc_return),
        .exc_return_num(exc_return_num),
        .exc_return_spsel(exc_return_spsel), .xfer_suspend(xfer_suspend),
        .xfer_next_reg(xfer_next_reg), .pred_load(pred_load),
        .pred_value(pred_value), .pred_advance(pred_advance),
        .gate_req(gate_req), .gate_num(gate_num), .gate_pri(gate_pri),
        .mrs_rdata_q(mrs_rdata_q), .mrs_done_q(mrs_done_q),
        .flags_q(flags_q), .exc_num_q(exc_num_q),
        .pri_block_q(pri_block_q), .flt_block_q(flt_block_q),
        .thresh_q(thresh_q), .spsel_q(spsel_q), .unpriv_q(unpriv_q),
        .xfer_held_q(xfer_held_q), .xfer_reg_q(xfer_reg_q),
        .xfer_resume_q(xfer_resume_q),
        .xfer_resume_reg_q(xfer_resume_reg_q),
        .pred_state_q(pred_state_q), .psr_stack_q(psr_stack_q),
        .gate_done_q(gate_done_q), .gate_allow_q(gate_allow_q));
    ////////////////////////////////////////////////////////////////////////
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] e, g);
        total_checks = total_checks + 1;
        if (e !== g) begin
            n_fail = n_fail + 1;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Ends every strobe except pred_load and pred_advance one cycle after it was raised
    task automatic tick();
        @(negedge mclk);
        {flag_upd, sat_hit, msr_valid, mrs_valid, cps_valid} = 5'h00;
        {exc_entry, exc_return, xfer_suspend, gate_req} = 4'h0;
    endtask : tick
    task automatic move_to_special_reg(input logic [4:0] s, input logic [31:0] d);
        @(negedge mclk);
        {msr_valid, msr_sel, msr_wdata} = {1'b1, s, d};
        tick();
    endtask : move_to_special_reg
    task automatic move_from_special_reg(input logic [4:0] s, input logic [31:0] e);
        @(negedge mclk);
        {mrs_valid, mrs_sel} = {1'b1, s};
        tick();
        chk("read done", 32'h1, {31'h0, mrs_done_q});
        chk("read data", e, mrs_rdata_q);
    endtask : move_from_special_reg
    task automatic flags(input logic [3:0] nzcv, input logic sat);
        @(negedge mclk);
        {flag_upd, flag_n, flag_z, flag_c, flag_v} = {~sat, nzcv};
        sat_hit = sat;
        tick();
    endtask : flags
    task automatic enter(input logic [8:0] n);
        @(negedge mclk);
        {exc_entry, exc_entry_num} = {1'b1, n};
        tick();
    endtask : enter
    task automatic leave();
        @(negedge mclk);
        {exc_return, exc_return_num, exc_return_spsel} = {1'b1, 9'h000, 1'b0};
        tick();
    endtask : leave
    task automatic change_processor_state(input logic set, pri, flt);
        @(negedge mclk);
        {cps_valid, cps_set, cps_pri, cps_flt} = {1'b1, set, pri, flt};
        tick();
    endtask : change_processor_state
    task automatic gate(input logic [8:0] n, input logic [7:0] p, input e);
        @(negedge mclk);
        {gate_req, gate_num, gate_pri} = {1'b1, n, p};
        tick();
        chk("gate done", 32'h1, {31'h0, gate_done_q});
        chk("gate allow", {31'h0, e}, {31'h0, gate_allow_q});
    endtask : gate
    ////////////////////////////////////////////////////////////////////////
    task automatic t_flags();
        flags(4'hA, 1'b0);
        chk("flags", 32'h14, {27'h0, flags_q});
        flags(4'h5, 1'b0);
        chk("flags", 32'h0A, {27'h0, flags_q});
        flags(4'h0, 1'b1);
        flags(4'h0, 1'b0);
        chk("sticky sat", 32'h01, {27'h0, flags_q});
        move_from_special_reg(csm_pkg::SEL_FLAGS, 32'h0800_0000);
        move_to_special_reg(csm_pkg::SEL_FLAGS, 32'hFFFF_FFFF);
        move_from_special_reg(csm_pkg::SEL_FLAGS, 32'hF800_0000);
        move_to_special_reg(csm_pkg::SEL_FLAGS, 32'h0);
        chk("sat cleared", 32'h0, {27'h0, flags_q});
        $display("test flags done");
    endtask : t_flags
    task automatic t_xfer();
        @(negedge mclk);
        {pred_load, pred_value} = {1'b1, 8'h1C};
        @(negedge mclk);
        {pred_load, pred_advance} = 2'b01;
        @(negedge mclk);
        pred_advance = 1'b0;
        chk("pred", 32'h18, {24'h0, pred_state_q});
        @(negedge mclk);
        {xfer_suspend, xfer_next_reg} = {1'b1, 4'h5};
        tick();
        chk("xfer reg", 32'h15, {27'h0, xfer_held_q, xfer_reg_q});
        move_from_special_reg(csm_pkg::SEL_EXEC, 32'h0);
        move_to_special_reg(csm_pkg::SEL_EXEC, 32'hFFFF_FFFF);
        chk("stacked", 32'h5, {psr_stack_q[26:25], psr_stack_q[15:10]}
            >> 2 | {psr_stack_q[11:10], 2'h0});
        enter(9'h010);
        leave();
        chk("resume", 32'h15, {xfer_resume_q, xfer_resume_reg_q});
        $display("test xfer done");
    endtask : t_xfer
    task automatic t_masks();
        change_processor_state(1'b1, 1'b1, 1'b0);
        chk("pri blk", 32'h1, {31'h0, pri_block_q});
        gate(9'h014, 8'h00, 1'b0);
        gate(9'h003, 8'h00, 1'b1);
        change_processor_state(1'b0, 1'b1, 1'b0);
        move_to_special_reg(csm_pkg::SEL_THRESH, 32'hFFFF_FFFF);
        move_from_special_reg(csm_pkg::SEL_THRESH, 32'h0000_00E0);
        gate(9'h014, 8'hE0, 1'b0);
        gate(9'h014, 8'hC0, 1'b1);
        move_to_special_reg(csm_pkg::SEL_THRESH, 32'h0);
        gate(9'h014, 8'hE0, 1'b1);
        move_to_special_reg(csm_pkg::SEL_FLTBLK, 32'hFFFF_FFFF);
        move_from_special_reg(csm_pkg::SEL_FLTBLK, 32'h1);
        gate(9'h003, 8'h00, 1'b0);
        gate(9'h002, 8'h00, 1'b1);
        enter(9'h005);
        leave();
        chk("flt cleared", 32'h0, {31'h0, flt_block_q});
        $display("test masks done");
    endtask : t_masks
    task automatic t_ctrl();
        move_to_special_reg(csm_pkg::SEL_CTRL, 32'hFFFF_FFFF);
        chk("ctrl", 32'h3, {30'h0, spsel_q, unpriv_q});
        move_to_special_reg(csm_pkg::SEL_CTRL, 32'h0);
        chk("ctrl", 32'h3, {30'h0, spsel_q, unpriv_q});
        enter(9'h014);
        chk("exc num", 32'h14, {23'h0, exc_num_q});
        move_to_special_reg(csm_pkg::SEL_EXCNUM, 32'h0);
        move_from_special_reg(csm_pkg::SEL_EXCNUM, 32'h14);
        move_from_special_reg(csm_pkg::SEL_CTRL, 32'h1);
        move_to_special_reg(csm_pkg::SEL_CTRL, 32'h2);
        chk("handler sp", 32'h0, {31'h0, spsel_q});
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {mclk, reset, cps_set, cps_pri, cps_flt, exc_return_spsel} = 6'h10;
        {flag_n, flag_z, flag_c, flag_v, pred_load, pred_advance} = 6'h00;
        {flag_upd, sat_hit, msr_valid, mrs_valid, cps_valid} = 5'h00;
        {exc_entry, exc_return, xfer_suspend, gate_req} = 4'h0;
        {msr_sel, mrs_sel, msr_wdata, exc_entry_num} = 51'h0;
        {exc_return_num, gate_num, xfer_next_reg, gate_pri} = 30'h0;
        {pred_value, n_fail, total_checks, cycles} = 0;
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        chk("reset psr", 32'h0100_0000, psr_stack_q);
        t_flags();
        t_xfer();
        t_masks();
        t_ctrl();
        final_report();
    end
endmodule : tb_top
